// ===== src/tape_cmd_pkg.sv
// constants for the tape command decoder
package tape_cmd_pkg;
  // command word bit positions (bit 0 is the msb of the bus word)
  localparam int unsigned POS_THRESH = 2;
  localparam int unsigned POS_EDIT = 6;
  localparam int unsigned POS_DENS = 7;
  localparam int unsigned POS_PACK = 8;
  localparam int unsigned POS_EVEN = 9;
  localparam int unsigned POS_FUNC = 10;
  localparam int unsigned POS_UNIT = 13;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] WC_RESET = 16'h0000;
  // control function codes
  localparam logic [1:0] CF_NONE = 2'h0;
  localparam logic [1:0] CF_START = 2'h1;
  localparam logic [1:0] CF_CLEAR = 2'h2;
  localparam logic [1:0] CF_PULSE = 2'h3;
  // function codes
  localparam logic [2:0] FN_READ = 3'h0;
  localparam logic [2:0] FN_REWIND = 3'h1;
  localparam logic [2:0] FN_NOP = 3'h2;
  localparam logic [2:0] FN_SPFWD = 3'h3;
  localparam logic [2:0] FN_SPREV = 3'h4;
  localparam logic [2:0] FN_WRITE = 3'h5;
  localparam logic [2:0] FN_WEOF = 3'h6;
  localparam logic [2:0] FN_ERASE = 3'h7;
  // erase run length in ns and in clock cycles
  localparam int unsigned ERASE_NS = 1000;
  localparam int unsigned CLK_NS = 4;
  localparam logic [15:0] ERASE_CYC = 16'(ERASE_NS / CLK_NS);
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_SPACE, ST_WRITE, ST_WEOF, ST_ERASE
  } op_state_t;
endpackage : tape_cmd_pkg

// ===== src/tape_command_decoder.sv
// command word decoder and operation sequencer for a tape controller
//
// Function
// - command bit 2 lowers the selected drive's read threshold
// - bit 6: next space reverse uses edit timing, next write overwrites
// - bit 7 drives the density select line
// - bit 8 selects 4-6-6 packing, else two six-bit chars per word (only drives pack_466; read always packs two 8-bit chars per word)
// - bit 9 selects even lateral parity, else odd
// - bits 10-12 decode to one of eight functions
// - start clears done, sets busy except on rewind and no-op; completion sets done and interrupts unless masked
// - rewind only pulses the drive, controller never goes busy
// - read stores words until end of record or word count overflow
// - odd length record right-justifies last byte, sets odd flag
// - data late on read keeps transferring until record end
// - a file mark read stores its one character and flags eof
// - space forward skips records, stops at file mark or eot record
// - zero spacing count means maximum count
// - space reverse at load point sets illegal, done and interrupt only
// - space reverse stops on file mark or load point
// - write requests a word at once, stops requesting on overflow or data late, ends on wr_done once no request is pending
// - write, file mark or erase on locked drive is rejected
// - erase runs the drive a short while then completes
// - bits 13-15 form the drive number, bit 13 most significant
// - start clears data late, parity, eof, bad tape and odd length, not illegal
// - clear also resets illegal and returns selection to unit zero
// - control field: none, start, clear (done and busy), pulse ignored
// - command while busy or drive not ready is rejected
`timescale 1ns/1ns
module tape_command_decoder (
  input wire logic clk,
  input wire logic rst,
  // command word output transfer strobe with its control function
  input wire logic command_word_output_transfer,
  input wire logic [15:0] bus_data,
  input wire logic [1:0] ctl_func,
  input wire logic ctl_strobe,
  input wire logic [15:0] word_count,
  input wire logic int_mask,
  // drive status (pins from the selected drive)
  input wire logic drv_ready,
  input wire logic drv_online,
  input wire logic drv_load_point,
  input wire logic drv_write_lock,
  input wire logic drv_eot,
  // formatter events, same clock
  input wire logic rd_char_valid,
  input wire logic [7:0] rd_char,
  input wire logic rd_end_record,
  input wire logic rd_file_mark,
  input wire logic rd_parity_err,
  input wire logic rd_bad_tape,
  input wire logic buf_data_late,
  input wire logic wr_word_ack,
  input wire logic wr_done,
  // outputs
  output logic [2:0] drive_number_field,
  output logic read_threshold_low,
  output logic edit_timing,
  output logic overwrite,
  output logic density_select,
  output logic pack_466,
  output logic even_parity,
  output logic rewind_pulse,
  output logic motion_fwd,
  output logic motion_rev,
  output logic write_enable,
  output logic write_file_mark,
  output logic erase_run,
  output logic chan_req,
  output logic chan_wr,
  output logic [15:0] chan_data,
  output logic busy,
  output logic done,
  output logic irq,
  output logic illegal,
  output logic err_data_late,
  output logic err_parity,
  output logic eof,
  output logic bad_tape,
  output logic odd_len,
  output logic error
);

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] wc;
    logic edit_arm;
    tape_cmd_pkg::op_state_t st;
    logic half;
    logic [7:0] hi;
    logic rewind;
    logic req;
    logic wr;
    logic [15:0] data;
    logic busy;
    logic done;
    logic irq;
    logic ill;
    logic late;
    logic par;
    logic eof;
    logic bad;
    logic odd;
    logic ovw;
    logic edt;
    logic [15:0] cnt;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [15:0] drv_sync1_q;
  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  logic [4:0] sy3_q;
  logic [4:0] dst_q;

  // bit n of the bus word is bit 15-n of the vector
  function automatic logic cbit(input logic [15:0] w, input int unsigned p);
    cbit = w[15 - p];
  endfunction : cbit

  function automatic logic [2:0] cfield(input logic [15:0] w,
                                        input int unsigned p);
    cfield = {w[15 - p], w[14 - p], w[13 - p]};
  endfunction : cfield

  ////////////////////////////////////////////////////////////////////
  // drive pins pass three flops; a change counts once stages 2 and 3 agree
  always_ff @(posedge clk) begin
    sy1_q <= {drv_ready, drv_online, drv_load_point, drv_write_lock,
              drv_eot};
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
    if (rst) begin
      dst_q <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (sy2_q[i] == sy3_q[i]) begin
          dst_q[i] <= sy3_q[i];
        end
      end
    end
  end

  logic s_rdy;
  logic s_onl;
  logic s_lpt;
  logic s_wlk;
  logic s_eot;
  assign {s_rdy, s_onl, s_lpt, s_wlk, s_eot} = dst_q;

  ////////////////////////////////////////////////////////////////////
  logic start;
  logic clr;
  logic [2:0] fn;
  logic fin;
  logic [15:0] wc_next;
  always_comb begin
    s_d = s_q;
    s_d.rewind = 1'b0;
    s_d.wr = 1'b0;
    s_d.irq = 1'b0;
    fin = 1'b0;
    start = 1'b0;
    clr = 1'b0;
    wc_next = s_q.wc + 16'h0001;
    if (command_word_output_transfer) begin
      s_d.cmd = bus_data;
      // edit bit arms the next reverse and write, same-cycle start too
      if (cbit(bus_data, tape_cmd_pkg::POS_EDIT)) begin
        s_d.edit_arm = 1'b1;
      end
    end
    if (ctl_strobe) begin
      start = (ctl_func == tape_cmd_pkg::CF_START);
      clr = (ctl_func == tape_cmd_pkg::CF_CLEAR);
    end
    fn = cfield(s_d.cmd, tape_cmd_pkg::POS_FUNC);
    // start clears these flags, illegal untouched cleared
    // ahead of the event logic so a flag raised in the same cycle wins
    if (start) begin
      s_d.late = 1'b0;
      s_d.par = 1'b0;
      s_d.eof = 1'b0;
      s_d.bad = 1'b0;
      s_d.odd = 1'b0;
    end
    case (s_q.st)
      tape_cmd_pkg::ST_READ: begin
        // data late is recorded but the transfer continues
        if (buf_data_late) begin
          s_d.late = 1'b1;
        end
        if (rd_parity_err) begin
          s_d.par = 1'b1;
        end
        if (rd_bad_tape) begin
          s_d.bad = 1'b1;
        end
        // pack bytes into words until overflow
        if (rd_char_valid) begin
          if (s_q.half) begin
            s_d.data = {s_q.hi, rd_char};
            s_d.wr = 1'b1;
            s_d.half = 1'b0;
            s_d.wc = wc_next;
            if (wc_next == 16'h0000) begin
              fin = 1'b1;
            end
          end else begin
            s_d.hi = rd_char;
            s_d.half = 1'b1;
          end
        end
        if (rd_end_record && !fin) begin
          if (s_d.half) begin
            s_d.data = {8'h00, s_d.hi};
            s_d.wr = 1'b1;
            s_d.odd = 1'b1;
            s_d.wc = wc_next;
          end
          // file mark character is stored, eof flagged
          if (rd_file_mark) begin
            s_d.eof = 1'b1;
          end
          fin = 1'b1;
        end
      end
      tape_cmd_pkg::ST_SPACE: begin
        if (rd_bad_tape) begin
          s_d.bad = 1'b1;
        end
        if (rd_end_record) begin
          s_d.wc = wc_next;
          // stop on file mark, eot or load point
          if (rd_file_mark) begin
            s_d.eof = 1'b1;
          end
          // zero count runs the full wrap before stopping
          if (rd_file_mark || wc_next == 16'h0000
              || (s_q.cmd[15 - tape_cmd_pkg::POS_FUNC - 2] && s_eot)) begin
            fin = 1'b1;
          end
        end
        if (motion_rev && s_lpt) begin
          fin = 1'b1;
        end
      end
      tape_cmd_pkg::ST_WRITE: begin
        // one word request outstanding at a time
        if (wr_word_ack) begin
          s_d.wc = wc_next;
          s_d.req = (wc_next != 16'h0000);
        end
        if (buf_data_late) begin
          s_d.late = 1'b1;
          s_d.req = 1'b0;
        end
        if (wr_done && !s_q.req) begin
          fin = 1'b1;
        end
      end
      tape_cmd_pkg::ST_WEOF: begin
        if (wr_done) begin
          s_d.eof = 1'b1;
          fin = 1'b1;
        end
      end
      tape_cmd_pkg::ST_ERASE: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0001) begin
          fin = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // completion clears busy, sets done, interrupt unless masked
    if (fin) begin
      s_d.st = tape_cmd_pkg::ST_IDLE;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.irq = !int_mask;
      s_d.req = 1'b0;
      s_d.ovw = 1'b0;
      s_d.edt = 1'b0;
    end
    if (start) begin
      s_d.done = 1'b0;
      if (s_q.busy || !s_rdy || !s_onl) begin
        s_d.ill = 1'b1;
        s_d.done = 1'b1;
        s_d.irq = !int_mask;
      end else if (s_wlk && (fn == tape_cmd_pkg::FN_WRITE
                   || fn == tape_cmd_pkg::FN_WEOF
                   || fn == tape_cmd_pkg::FN_ERASE)) begin
        s_d.ill = 1'b1;
        s_d.done = 1'b1;
        s_d.irq = !int_mask;
      end else if (s_lpt && fn == tape_cmd_pkg::FN_SPREV) begin
        s_d.ill = 1'b1;
        s_d.done = 1'b1;
        s_d.irq = !int_mask;
      end else begin
        // a refused start must not disturb the count of a running transfer
        s_d.wc = word_count;
        s_d.half = 1'b0;
        case (fn)
          tape_cmd_pkg::FN_REWIND: s_d.rewind = 1'b1;
          tape_cmd_pkg::FN_NOP: begin
            s_d.done = 1'b1;
            s_d.irq = !int_mask;
          end
          tape_cmd_pkg::FN_READ: s_d.st = tape_cmd_pkg::ST_READ;
          tape_cmd_pkg::FN_SPFWD,
          tape_cmd_pkg::FN_SPREV: s_d.st = tape_cmd_pkg::ST_SPACE;
          tape_cmd_pkg::FN_WRITE: s_d.st = tape_cmd_pkg::ST_WRITE;
          tape_cmd_pkg::FN_WEOF: s_d.st = tape_cmd_pkg::ST_WEOF;
          default: begin
            s_d.st = tape_cmd_pkg::ST_ERASE;
            s_d.cnt = tape_cmd_pkg::ERASE_CYC;
          end
        endcase
        if (fn != tape_cmd_pkg::FN_REWIND && fn != tape_cmd_pkg::FN_NOP) begin
          s_d.busy = 1'b1;
        end
        s_d.req = (fn == tape_cmd_pkg::FN_WRITE);
        // edit arm used by reverse, cleared only by write
        s_d.edt = s_d.edit_arm && fn == tape_cmd_pkg::FN_SPREV;
        s_d.ovw = s_d.edit_arm && fn == tape_cmd_pkg::FN_WRITE;
        if (fn == tape_cmd_pkg::FN_WRITE) begin
          s_d.edit_arm = 1'b0;
        end
      end
    end
    // clear: flags, illegal, busy, done, unit zero
    if (clr) begin
      s_d.late = 1'b0;
      s_d.par = 1'b0;
      s_d.eof = 1'b0;
      s_d.bad = 1'b0;
      s_d.odd = 1'b0;
      s_d.ill = 1'b0;
      s_d.busy = 1'b0;
      s_d.done = 1'b0;
      s_d.req = 1'b0;
      s_d.st = tape_cmd_pkg::ST_IDLE;
      s_d.cmd[2:0] = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs are flops, fixed slices of flops or decodes of the state and command flops
  always_comb begin
    drive_number_field = cfield(s_q.cmd, tape_cmd_pkg::POS_UNIT);
    read_threshold_low = cbit(s_q.cmd, tape_cmd_pkg::POS_THRESH);
    density_select = cbit(s_q.cmd, tape_cmd_pkg::POS_DENS);
    pack_466 = cbit(s_q.cmd, tape_cmd_pkg::POS_PACK);
    even_parity = cbit(s_q.cmd, tape_cmd_pkg::POS_EVEN);
    edit_timing = s_q.edt;
    overwrite = s_q.ovw;
    rewind_pulse = s_q.rewind;
    motion_fwd = s_q.st == tape_cmd_pkg::ST_READ
                 || (s_q.st == tape_cmd_pkg::ST_SPACE
                     && !s_q.cmd[15 - tape_cmd_pkg::POS_FUNC]);
    motion_rev = s_q.st == tape_cmd_pkg::ST_SPACE
                 && s_q.cmd[15 - tape_cmd_pkg::POS_FUNC];
    write_enable = s_q.st == tape_cmd_pkg::ST_WRITE;
    write_file_mark = s_q.st == tape_cmd_pkg::ST_WEOF;
    erase_run = s_q.st == tape_cmd_pkg::ST_ERASE;
    chan_req = s_q.req;
    chan_wr = s_q.wr;
    chan_data = s_q.data;
    busy = s_q.busy;
    done = s_q.done;
    irq = s_q.irq;
    illegal = s_q.ill;
    err_data_late = s_q.late;
    err_parity = s_q.par;
    eof = s_q.eof;
    bad_tape = s_q.bad;
    odd_len = s_q.odd;
    error = s_q.late | s_q.par | s_q.eof | s_q.bad | s_q.odd | s_q.ill;
  end

  ////////////////////////////////////////////////////////////////////
  // read start on idle ready drive goes busy with done low
  AST_START_BUSY: assert property (@(posedge clk) disable iff (rst)
    start && !s_q.busy && s_rdy && s_onl && !s_wlk && !s_lpt
    && !clr && fn == tape_cmd_pkg::FN_READ |=> busy && !done)
    else $error("start did not go busy");

  AST_REWIND: assert property (@(posedge clk) disable iff (rst)
    start && !s_q.busy && s_rdy && s_onl && !clr
    && fn == tape_cmd_pkg::FN_REWIND |=> rewind_pulse && !busy)
    else $error("rewind went busy");

  AST_BUSY_REJ: assert property (@(posedge clk) disable iff (rst)
    start && s_q.busy && !clr |=> illegal && done)
    else $error("busy start not rejected");

  AST_ILL_HOLD: assert property (@(posedge clk) disable iff (rst)
    illegal && !clr |=> illegal)
    else $error("illegal dropped without clear");

  AST_CLEAR: assert property (@(posedge clk) disable iff (rst)
    clr |=> !illegal && !busy && drive_number_field == 3'h0)
    else $error("clear incomplete");

  AST_START_CLR: assert property (@(posedge clk) disable iff (rst)
    start && !clr && s_q.st == tape_cmd_pkg::ST_IDLE
    |=> !err_data_late && !eof)
    else $error("start left flags set");

  AST_LPT: assert property (@(posedge clk) disable iff (rst)
    start && !clr && !s_q.busy && s_rdy && s_onl && s_lpt
    && fn == tape_cmd_pkg::FN_SPREV |=> illegal && !busy)
    else $error("reverse at load point started");

  AST_WLOCK: assert property (@(posedge clk) disable iff (rst)
    start && !clr && !s_q.busy && s_rdy && s_onl && s_wlk
    && fn == tape_cmd_pkg::FN_WRITE |=> illegal && !write_enable)
    else $error("locked write started");

  // erase ends within 260 cycles, ten past its run length
  AST_ERASE: assert property (@(posedge clk) disable iff (rst)
    $rose(erase_run) |-> ##[1:260] done)
    else $error("erase did not complete");

endmodule : tape_command_decoder

// ===== sim/host_bus_model.sv
// host bus and data channel model on the decoder's host side
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk,
  output logic command_word_output_transfer,
  output logic [15:0] bus_data,
  output logic [1:0] ctl_func,
  output logic ctl_strobe,
  output logic [15:0] word_count,
  output logic int_mask,
  input wire logic chan_req,
  input wire logic chan_wr,
  input wire logic [15:0] chan_data,
  output logic wr_word_ack
);
  int ack_wait = 0;
  int ack_cnt = 0;
  int n = 0;
  logic [15:0] rx_q[$];
  initial begin
    command_word_output_transfer = 1'b0;
    bus_data = 16'h0000;
    ctl_func = 2'h0;
    ctl_strobe = 1'b0;
    word_count = 16'h0000;
    int_mask = 1'b0;
    wr_word_ack = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one bus cycle with control function and count
  // bus is not held after the cycle, so it shows the inverse
  task automatic io(input logic x, input logic [15:0] w,
                    input logic [1:0] f, input logic [15:0] c);
    @(negedge clk);
    command_word_output_transfer = x;
    bus_data = w;
    ctl_func = f;
    ctl_strobe = 1'b1;
    word_count = c;
    @(negedge clk);
    command_word_output_transfer = 1'b0;
    ctl_strobe = 1'b0;
    bus_data = ~w;
    ctl_func = ~f;
    word_count = ~c;
  endtask : io
  //////////////////////////////////////////////////////////////////////////
  // ack_wait stretches the answer to mimic a slow channel
  always @(negedge clk) begin
    if (wr_word_ack) begin
      wr_word_ack = 1'b0;
    end else if (chan_req && n >= ack_wait) begin
      wr_word_ack = 1'b1;
      ack_cnt++;
      n = 0;
    end else if (chan_req) begin
      n++;
    end
  end
  always @(posedge clk) begin
    if (chan_wr) begin
      rx_q.push_back(chan_data);
    end
  end
endmodule : host_bus_model

// ===== sim/tb_top.sv
// self-checking bench for the tape command decoder
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [15:0] w;
    logic [7:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic command_word_output_transfer, ctl_strobe, int_mask, wr_word_ack;
  logic [15:0] bus_data, word_count, chan_data;
  logic [1:0] ctl_func;
  logic drv_ready = 1'b1, drv_online = 1'b1, drv_load_point = 1'b0;
  logic drv_write_lock = 1'b0, drv_eot = 1'b0, rd_bad_tape = 1'b0;
  logic rd_char_valid = 1'b0, rd_end_record = 1'b0, rd_file_mark = 1'b0;
  logic rd_parity_err = 1'b0, buf_data_late = 1'b0, wr_done = 1'b0;
  logic [7:0] rd_char = 8'h00;
  logic [2:0] drive_number_field;
  logic read_threshold_low, edit_timing, overwrite, density_select;
  logic pack_466, even_parity, rewind_pulse, motion_fwd, motion_rev;
  logic write_enable, write_file_mark, erase_run, chan_req, chan_wr;
  logic busy, done, irq, illegal, err_data_late, err_parity, eof;
  logic bad_tape, odd_len, error;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int rw_cnt = 0;
  int k;
  int n0;
  // command word beside {0,thr,dens,pack,even,unit}
  row_t rows[6] = '{'{16'h2014, 8'h44}, '{16'h0111, 8'h21},
    '{16'h0092, 8'h12}, '{16'h0057, 8'h0f}, '{16'h21d3, 8'h7b},
    '{16'h0016, 8'h06}};
  logic [2:0] lock_fn[3] = '{tape_cmd_pkg::FN_WRITE,
    tape_cmd_pkg::FN_WEOF, tape_cmd_pkg::FN_ERASE};

  tape_command_decoder i_tape_command_decoder (
    .clk, .rst, .command_word_output_transfer, .bus_data, .ctl_func,
    .ctl_strobe, .word_count, .int_mask, .drv_ready, .drv_online,
    .drv_load_point, .drv_write_lock, .drv_eot, .rd_char_valid, .rd_char,
    .rd_end_record, .rd_file_mark, .rd_parity_err, .rd_bad_tape,
    .buf_data_late, .wr_word_ack, .wr_done, .drive_number_field,
    .read_threshold_low, .edit_timing, .overwrite, .density_select,
    .pack_466, .even_parity, .rewind_pulse, .motion_fwd, .motion_rev,
    .write_enable, .write_file_mark, .erase_run, .chan_req, .chan_wr,
    .chan_data, .busy, .done, .irq, .illegal, .err_data_late,
    .err_parity, .eof, .bad_tape, .odd_len, .error
  );
  host_bus_model i_host_bus_model (
    .clk, .command_word_output_transfer, .bus_data, .ctl_func, .ctl_strobe,
    .word_count, .int_mask, .chan_req, .chan_wr, .chan_data, .wr_word_ack
  );

  always #2 clk = ~clk;
  // ceiling far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
    if (rewind_pulse === 1'b1) rw_cnt++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic go(input logic [2:0] f, input logic [2:0] u,
                    input logic [4:0] o, input logic [15:0] c);
    i_host_bus_model.io(1'b1, {2'h0, o[4], 3'h0, o[3:0], f, u},
                        tape_cmd_pkg::CF_START, c);
  endtask : go
  task automatic clr();
    i_host_bus_model.io(1'b0, 16'h0000, tape_cmd_pkg::CF_CLEAR, 16'h0000);
  endtask : clr
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic chr(input logic [7:0] c);
    rd_char = c;
    pulse(rd_char_valid);
    rd_char = ~c;
  endtask : chr
  task automatic wait_done(input int lim);
    for (k = 0; k < lim && done !== 1'b1; k++) @(negedge clk);
    // irq and the last channel word are counted at the next rising edge
    @(negedge clk);
  endtask : wait_done
  task automatic fin(input string nm);
    $display("test %s finished", nm);
  endtask : fin
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_bit("done after reset", 1'b0, done);
    chk_bit("illegal after reset", 1'b0, illegal);
    // drive status passes a synchroniser before it counts
    repeat (8) @(negedge clk);
    foreach (rows[i]) begin
      i_host_bus_model.io(1'b1, rows[i].w, tape_cmd_pkg::CF_NONE, 16'h0);
      chk_word("static outs", {8'h00, rows[i].e}, {8'h00, 1'b0,
        read_threshold_low, density_select, pack_466, even_parity,
        drive_number_field});
      chk_bit("busy without start", 1'b0, busy);
    end
    fin("table");
    go(tape_cmd_pkg::FN_READ, 3'h0, 5'h00, 16'hfffc);
    chk_bit("read busy", 1'b1, busy);
    chk_bit("read done", 1'b0, done);
    chk_bit("read motion", 1'b1, motion_fwd);
    chr(8'h5a);
    pulse(buf_data_late);
    chr(8'hc3);
    pulse(rd_parity_err);
    chr(8'h7e);
    chk_bit("busy after late", 1'b1, busy);
    n0 = irq_cnt;
    pulse(rd_end_record);
    wait_done(4);
    chk_bit("read end busy", 1'b0, busy);
    chk_word("read irq", 16'(n0 + 1), 16'(irq_cnt));
    chk_word("words", 16'h2, 16'(i_host_bus_model.rx_q.size()));
    chk_word("first word", 16'h5ac3, i_host_bus_model.rx_q[0]);
    chk_word("last word", 16'h007e, i_host_bus_model.rx_q[1]);
    chk_bit("odd length", 1'b1, odd_len);
    chk_bit("late flag", 1'b1, err_data_late);
    fin("read");
    i_host_bus_model.int_mask = 1'b1;
    n0 = irq_cnt;
    go(tape_cmd_pkg::FN_NOP, 3'h0, 5'h00, 16'h0000);
    wait_done(4);
    chk_bit("late cleared", 1'b0, err_data_late);
    chk_bit("parity cleared", 1'b0, err_parity);
    chk_word("masked irq", 16'(n0), 16'(irq_cnt));
    i_host_bus_model.int_mask = 1'b0;
    n0 = rw_cnt;
    go(tape_cmd_pkg::FN_REWIND, 3'h5, 5'h00, 16'h0000);
    @(negedge clk);
    chk_word("rewind pulses", 16'(n0 + 1), 16'(rw_cnt));
    chk_bit("rewind busy", 1'b0, busy);
    chk_word("unit", 16'h5, {13'h0, drive_number_field});
    go(tape_cmd_pkg::FN_READ, 3'h0, 5'h00, 16'hfffc);
    chr(8'h13);
    rd_file_mark = 1'b1;
    pulse(rd_end_record);
    rd_file_mark = 1'b0;
    wait_done(4);
    chk_word("mark char", 16'h0013, i_host_bus_model.rx_q[2]);
    chk_bit("mark eof", 1'b1, eof);
    fin("nop and rewind");
    go(tape_cmd_pkg::FN_SPREV, 3'h0, 5'h08, 16'h0000);
    chk_bit("edit timing", 1'b1, edit_timing);
    chk_bit("reverse motion", 1'b1, motion_rev);
    repeat (3) pulse(rd_end_record);
    chk_bit("zero count busy", 1'b1, busy);
    // a file mark is flagged together with the end of its record
    rd_file_mark = 1'b1;
    pulse(rd_end_record);
    rd_file_mark = 1'b0;
    wait_done(8);
    chk_bit("reverse eof", 1'b1, eof);
    // slow channel: each word waits three extra cycles
    i_host_bus_model.ack_wait = 3;
    n0 = i_host_bus_model.ack_cnt;
    go(tape_cmd_pkg::FN_WRITE, 3'h0, 5'h08, 16'hfffe);
    chk_bit("write request", 1'b1, chan_req);
    chk_bit("overwrite", 1'b1, overwrite);
    for (k = 0; k < 40 && chan_req === 1'b1; k++) @(negedge clk);
    chk_word("acks", 16'h2, 16'(i_host_bus_model.ack_cnt - n0));
    chk_bit("write busy", 1'b1, busy);
    pulse(wr_done);
    wait_done(8);
    chk_bit("write done", 1'b1, done);
    fin("edit pair");
    go(tape_cmd_pkg::FN_SPFWD, 3'h0, 5'h00, 16'hfffe);
    pulse(rd_end_record);
    chk_bit("one record left", 1'b1, busy);
    pulse(rd_bad_tape);
    pulse(rd_end_record);
    wait_done(8);
    chk_bit("spaced two", 1'b1, done);
    chk_bit("space bad tape", 1'b1, bad_tape);
    go(tape_cmd_pkg::FN_WEOF, 3'h0, 5'h00, 16'h0000);
    chk_bit("bad tape cleared", 1'b0, bad_tape);
    chk_bit("file mark write", 1'b1, write_file_mark);
    pulse(wr_done);
    wait_done(8);
    chk_bit("file mark eof", 1'b1, eof);
    chk_bit("error summary", 1'b1, error);
    go(tape_cmd_pkg::FN_ERASE, 3'h0, 5'h00, 16'h0000);
    chk_bit("erase running", 1'b1, erase_run);
    wait_done(400);
    chk_bit("erase done", 1'b1, done);
    chk_bit("erase length", 1'b1, logic'(k > 200));
    fin("space and erase");
    go(tape_cmd_pkg::FN_READ, 3'h0, 5'h00, 16'hfffc);
    i_host_bus_model.io(1'b0, 16'h0, tape_cmd_pkg::CF_START, 16'h0);
    chk_bit("start while busy", 1'b1, illegal);
    i_host_bus_model.io(1'b0, 16'h0, tape_cmd_pkg::CF_PULSE, 16'h0);
    chk_bit("pulse ignored", 1'b1, busy);
    clr();
    chk_bit("clear busy", 1'b0, busy);
    chk_bit("clear done", 1'b0, done);
    chk_bit("clear illegal", 1'b0, illegal);
    drv_write_lock = 1'b1;
    repeat (8) @(negedge clk);
    foreach (lock_fn[i]) begin
      go(lock_fn[i], 3'h2, 5'h00, 16'hffff);
      chk_bit("locked illegal", 1'b1, illegal);
      chk_bit("locked busy", 1'b0, busy);
      chk_bit("locked done", 1'b1, done);
      go(tape_cmd_pkg::FN_NOP, 3'h2, 5'h00, 16'h0000);
      chk_bit("illegal kept", 1'b1, illegal);
      clr();
      chk_word("unit", 16'h0, {13'h0, drive_number_field});
    end
    drv_write_lock = 1'b0;
    drv_load_point = 1'b1;
    repeat (8) @(negedge clk);
    go(tape_cmd_pkg::FN_SPREV, 3'h0, 5'h00, 16'hffff);
    chk_bit("load point reject", 1'b1, illegal);
    chk_bit("no reverse", 1'b0, motion_rev);
    clr();
    drv_load_point = 1'b0;
    drv_ready = 1'b0;
    repeat (8) @(negedge clk);
    go(tape_cmd_pkg::FN_READ, 3'h0, 5'h00, 16'hfffc);
    chk_bit("not ready reject", 1'b1, illegal);
    chk_bit("not ready done", 1'b1, done);
    drv_ready = 1'b1;
    fin("rejections");
    test_done();
  end
endmodule : tb_top
